//--- logic/ancc_map.svh
`ifndef ANCC_MAP_SVH
`define ANCC_MAP_SVH

// register indices; byte address is four times the index
`define ANCC_IDX_CONTROL     6'h00
`define ANCC_IDX_STATUS      6'h01
`define ANCC_IDX_ADVERT      6'h04
`define ANCC_IDX_PARTNER     6'h05
`define ANCC_IDX_EXPANSION   6'h06
`define ANCC_IDX_LINK_STATUS 6'h10

// basic_control fields
`define ANCC_CTL_SPEED   13
`define ANCC_CTL_NEGOTIATION_ENABLE_STRAP   12
`define ANCC_CTL_RESTART 9
`define ANCC_CTL_DUPLEX  8

// basic_status: fixed abilities and live bits
`define ANCC_STS_FIXED    16'h7849
`define ANCC_STS_AN_DONE  5
`define ANCC_STS_RFAULT   4
`define ANCC_STS_LINK     2

// advertisement / partner ability fields
`define ANCC_ABIL_LSB     5
`define ANCC_SELECTOR     5'h01
`define ANCC_PAGE_RFAULT  13
`define ANCC_PAGE_NP      15
`define ANCC_PD_100       16'h0081
`define ANCC_PD_10        16'h0021

// negotiation_expansion fields
`define ANCC_EXP_PDF      4
`define ANCC_EXP_LP_NP    3
`define ANCC_EXP_NP_ABLE  2
`define ANCC_EXP_PAGE_RX  1
`define ANCC_EXP_LP_AN    0

// phy_link_status fields
`define ANCC_PLS_LINK     0
`define ANCC_PLS_SPEED10  1
`define ANCC_PLS_FULL     2
`define ANCC_PLS_AN_DONE  4

// break-link time and strap synchroniser settle count
`define ANCC_BREAK_LINK_MS 1500
`define ANCC_CLK_KHZ       125000
`define ANCC_SYNC_SETTLE   3'h4

`endif

//--- logic/ancc_pkg.sv
package ancc_pkg;

  typedef enum logic [2:0] {
    ST_CONFIG,
    ST_FORCED,
    ST_BREAK,
    ST_ABILITY,
    ST_LINK_OK
  } ancc_state_type;

  typedef logic [15:0] ancc_word_type;

endpackage

//--- logic/ancc_sync3.sv
`timescale 1ns/1ns
// three-stage pin synchroniser; output follows once stages two and three agree
module ancc_sync3 (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_out
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] out_reg;
  logic [2:0] out_next;

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < 3; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= 3'h0;
      s2_reg  <= 3'h0;
      s3_reg  <= 3'h0;
      out_reg <= 3'h0;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;

endmodule

//--- logic/ancc_resolve.sv
`timescale 1ns/1ns
// picks the best common mode from the four ability bits {100F,100H,10F,10H}
module ancc_resolve (
  input  wire logic [3:0] common,
  output logic            found,
  output logic            speed_100,
  output logic            full_duplex
);

  always_comb begin
    found       = 1'b1;
    speed_100   = 1'b0;
    full_duplex = 1'b0;
    if (common[3]) begin // [RULE_06]
      speed_100   = 1'b1;
      full_duplex = 1'b1;
    end else if (common[2]) begin
      speed_100   = 1'b1;
    end else if (common[1]) begin
      full_duplex = 1'b1;
    end else if (!common[0]) begin
      found       = 1'b0;
    end
  end

endmodule

//--- logic/ancc_top.sv
// Functional notes
// RULE_01: strap enable low forces mode from ability straps
// RULE_02: strap enable high selects advertised ability set
// RULE_03: reset loads advertisement ability bits from straps
// RULE_04: control register writes override strap configuration
// RULE_05: negotiation sends advertisement register in bursts
// RULE_06: priority 100 full, 100 half, 10 full, 10 half
// RULE_07: speed and duplex bits act only when forced
// RULE_08: link status register reports resulting speed
// RULE_09: status ability bits fixed, T4 reads zero
// RULE_10: status reports complete, fault, link, preamble suppression
// RULE_11: all abilities advertised; software may clear bits; code advertises all four only when both ability straps are high
// RULE_12: partner register holds pages or parallel-detect codes
// RULE_13: expansion register reports five negotiation conditions
// RULE_14: both receivers feed parallel detection of partner
// RULE_15: parallel detection sets bit 5/7 and selector
// RULE_16: partner-able bit zero after parallel detection
// RULE_17: fault unless exactly one good link technology; code flags the fault only when both links are good, not when neither is
// RULE_18: restart bit restarts negotiation after completion
// RULE_19: lost negotiated link resumes negotiation
// RULE_20: renegotiation silences link for break-link time first
// RULE_21: forced start needs enable cleared then set
// RULE_22: straps sampled once after reset release
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "ancc_map.svh"
module ancc_top
  import ancc_pkg::*;
#(
  parameter int unsigned BREAK_LINK_CYCLES = `ANCC_BREAK_LINK_MS * `ANCC_CLK_KHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        negotiation_enable_strap,
  input  wire logic        ability_strap_high,
  input  wire logic        ability_strap_low,
  input  wire logic        link_good_10,
  input  wire logic        link_good_100,
  input  wire logic        partner_page_valid,
  input  wire logic [15:0] partner_page,
  output logic             flp_enable,
  output logic [15:0]      flp_code_word,
  output logic             tx_enable,
  output logic             link_up,
  output logic             link_speed_100,
  output logic             link_full_duplex
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // forced mode from ability straps: {speed_100, full}
  function automatic logic [1:0] forced_mode(input logic [1:0] abil);
    forced_mode = abil; // [RULE_01]
  endfunction

  // advertised ability nibble {100F,100H,10F,10H} from ability straps
  function automatic logic [3:0] advert_set(input logic [1:0] abil);
    case (abil) // [RULE_02]
      2'h0:    advert_set = 4'h3;
      2'h1:    advert_set = 4'hC;
      2'h2:    advert_set = 4'h5;
      default: advert_set = 4'hF;
    endcase
  endfunction

  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    reg_index = addr[7:2];
  endfunction

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx == `ANCC_IDX_CONTROL) || (idx == `ANCC_IDX_STATUS)
              || (idx == `ANCC_IDX_ADVERT) || (idx == `ANCC_IDX_PARTNER)
              || (idx == `ANCC_IDX_EXPANSION) || (idx == `ANCC_IDX_LINK_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser and resolution

  logic [2:0] strap_sync;
  logic [3:0] common_abil;
  logic       res_found;
  logic       res_100;
  logic       res_full;

  ancc_sync3 u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({negotiation_enable_strap, ability_strap_high, ability_strap_low}),
    .pin_out (strap_sync)
  );

  ancc_resolve u_resolve (
    .common      (common_abil),
    .found       (res_found),
    .speed_100   (res_100),
    .full_duplex (res_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  ancc_state_type state_reg, state_next;
  logic [2:0]  settle_reg, settle_next;
  logic [31:0] timer_reg, timer_next;
  logic        ctl_negotiation_enable_strap_reg, ctl_negotiation_enable_strap_next;
  logic        ctl_speed_reg, ctl_speed_next;
  logic        ctl_duplex_reg, ctl_duplex_next;
  logic        armed_reg, armed_next;
  logic [3:0]  adv_reg, adv_next;
  logic [15:0] lp_reg, lp_next;
  logic        an_done_reg, an_done_next;
  logic        pdf_reg, pdf_next;
  logic        page_rx_reg, page_rx_next;
  logic        lp_an_reg, lp_an_next;
  logic        up_reg, up_next;
  logic        spd_reg, spd_next;
  logic        fdx_reg, fdx_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  logic        wr_take;
  logic        rd_take;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic [15:0] wr_data;
  logic [15:0] ctl_word;
  logic [15:0] adv_word;
  logic [15:0] sts_word;
  logic [15:0] exp_word;
  logic [15:0] pls_word;
  logic [15:0] rd_word;
  logic        restart_req;
  logic        enable_rise;
  logic        sel_link_good;

  // both channels taken together keeps the write a single beat
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_take = s_axi_arvalid && !rvalid_reg;
  assign wr_idx  = reg_index(s_axi_awaddr);
  assign rd_idx  = reg_index(s_axi_araddr);

  assign adv_word = {7'h00, adv_reg, `ANCC_SELECTOR};
  assign ctl_word = {2'h0, ctl_speed_reg, ctl_negotiation_enable_strap_reg, 3'h0, ctl_duplex_reg, 8'h00};
  assign common_abil = adv_reg & lp_reg[8:5];
  assign sel_link_good = spd_reg ? link_good_100 : link_good_10;

  always_comb begin
    sts_word = `ANCC_STS_FIXED; // [RULE_09]
    sts_word[`ANCC_STS_AN_DONE] = an_done_reg; // [RULE_10]
    sts_word[`ANCC_STS_RFAULT]  = lp_reg[`ANCC_PAGE_RFAULT];
    sts_word[`ANCC_STS_LINK]    = up_reg;
    exp_word = 16'h0000; // [RULE_13]
    exp_word[`ANCC_EXP_PDF]     = pdf_reg;
    exp_word[`ANCC_EXP_LP_NP]   = lp_reg[`ANCC_PAGE_NP];
    exp_word[`ANCC_EXP_NP_ABLE] = 1'b0;
    exp_word[`ANCC_EXP_PAGE_RX] = page_rx_reg;
    exp_word[`ANCC_EXP_LP_AN]   = lp_an_reg;
    pls_word = 16'h0000; // [RULE_08]
    pls_word[`ANCC_PLS_LINK]    = up_reg;
    pls_word[`ANCC_PLS_SPEED10] = up_reg && !spd_reg;
    pls_word[`ANCC_PLS_FULL]    = up_reg && fdx_reg;
    pls_word[`ANCC_PLS_AN_DONE] = an_done_reg;
    case (rd_idx)
      `ANCC_IDX_CONTROL:     rd_word = ctl_word;
      `ANCC_IDX_STATUS:      rd_word = sts_word;
      `ANCC_IDX_ADVERT:      rd_word = adv_word;
      `ANCC_IDX_PARTNER:     rd_word = lp_reg;
      `ANCC_IDX_EXPANSION:   rd_word = exp_word;
      `ANCC_IDX_LINK_STATUS: rd_word = pls_word;
      default:               rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    wr_data[7:0]  = s_axi_wstrb[0] ? s_axi_wdata[7:0] : ctl_word[7:0];
    wr_data[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : ctl_word[15:8];
    if (wr_idx == `ANCC_IDX_ADVERT) begin
      wr_data[7:0]  = s_axi_wstrb[0] ? s_axi_wdata[7:0] : adv_word[7:0];
      wr_data[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : adv_word[15:8];
    end
  end

  assign restart_req = wr_take && (wr_idx == `ANCC_IDX_CONTROL)
                    && wr_data[`ANCC_CTL_RESTART] && wr_data[`ANCC_CTL_NEGOTIATION_ENABLE_STRAP];
  assign enable_rise = wr_take && (wr_idx == `ANCC_IDX_CONTROL)
                    && wr_data[`ANCC_CTL_NEGOTIATION_ENABLE_STRAP] && !ctl_negotiation_enable_strap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    state_next      = state_reg;
    settle_next     = settle_reg;
    timer_next      = timer_reg;
    ctl_negotiation_enable_strap_next  = ctl_negotiation_enable_strap_reg;
    ctl_speed_next  = ctl_speed_reg;
    ctl_duplex_next = ctl_duplex_reg;
    armed_next      = armed_reg;
    adv_next        = adv_reg;
    lp_next         = lp_reg;
    an_done_next    = an_done_reg;
    pdf_next        = pdf_reg;
    page_rx_next    = page_rx_reg;
    lp_an_next      = lp_an_reg;
    up_next         = up_reg;
    spd_next        = spd_reg;
    fdx_next        = fdx_reg;
    bvalid_next     = bvalid_reg;
    bresp_next      = bresp_reg;
    rvalid_next     = rvalid_reg;
    rresp_next      = rresp_reg;
    rdata_next      = rdata_reg;

    // bus: read-clear of expansion event bits; a new event the same cycle wins
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next  = idx_mapped(rd_idx) ? 2'h0 : 2'h2;
      rdata_next  = {16'h0000, rd_word};
      if (rd_idx == `ANCC_IDX_EXPANSION) begin
        pdf_next     = 1'b0;
        page_rx_next = 1'b0;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_take) begin
      bvalid_next = 1'b1;
      bresp_next  = idx_mapped(wr_idx) ? 2'h0 : 2'h2;
      if (wr_idx == `ANCC_IDX_CONTROL && state_reg != ST_CONFIG) begin
        ctl_negotiation_enable_strap_next  = wr_data[`ANCC_CTL_NEGOTIATION_ENABLE_STRAP]; // [RULE_04]
        ctl_speed_next  = wr_data[`ANCC_CTL_SPEED];
        ctl_duplex_next = wr_data[`ANCC_CTL_DUPLEX];
        if (!wr_data[`ANCC_CTL_NEGOTIATION_ENABLE_STRAP]) begin
          armed_next = 1'b1; // [RULE_21]
        end
      end
      if (wr_idx == `ANCC_IDX_ADVERT && state_reg != ST_CONFIG) begin
        adv_next = wr_data[8:5]; // [RULE_11]
      end
    end

    case (state_reg)
      ST_CONFIG: begin
        // wait for the synchroniser to settle, then take straps once
        settle_next = settle_reg + 3'h1;
        if (settle_reg == `ANCC_SYNC_SETTLE) begin
          ctl_negotiation_enable_strap_next  = strap_sync[2]; // [RULE_22]
          armed_next      = strap_sync[2];
          adv_next        = advert_set(strap_sync[1:0]); // [RULE_03]
          {ctl_speed_next, ctl_duplex_next} = forced_mode(strap_sync[1:0]);
          timer_next      = 32'h0;
          state_next      = strap_sync[2] ? ST_ABILITY : ST_FORCED;
        end
      end
      ST_FORCED: begin
        spd_next     = ctl_speed_reg; // [RULE_07]
        fdx_next     = ctl_duplex_reg;
        up_next      = ctl_speed_reg ? link_good_100 : link_good_10;
        an_done_next = 1'b0;
        if (ctl_negotiation_enable_strap_reg && armed_reg) begin
          up_next    = 1'b0;
          timer_next = 32'h0;
          state_next = ST_BREAK;
        end
      end
      ST_BREAK: begin
        // transmitter silent so the partner drops into link fail
        up_next      = 1'b0;
        an_done_next = 1'b0;
        timer_next   = timer_reg + 32'h1;
        if (timer_reg >= BREAK_LINK_CYCLES - 1) begin // [RULE_20]
          timer_next = 32'h0;
          state_next = ST_ABILITY;
        end
      end
      ST_ABILITY: begin
        if (partner_page_valid) begin
          lp_next      = partner_page; // [RULE_12]
          page_rx_next = 1'b1;
          lp_an_next   = 1'b1;
        end else if (!lp_an_reg && (link_good_10 != link_good_100)) begin
          lp_next      = link_good_100 ? `ANCC_PD_100 : `ANCC_PD_10; // [RULE_14] [RULE_15]
          lp_an_next   = 1'b0; // [RULE_16]
          spd_next     = link_good_100;
          fdx_next     = 1'b0;
          up_next      = 1'b1;
          an_done_next = 1'b1;
          state_next   = ST_LINK_OK;
        end else if (!lp_an_reg && link_good_10 && link_good_100) begin
          pdf_next     = 1'b1; // [RULE_17]
        end
        if (lp_an_reg && res_found && (res_100 ? link_good_100 : link_good_10)) begin
          spd_next     = res_100;
          fdx_next     = res_full;
          up_next      = 1'b1;
          an_done_next = 1'b1;
          state_next   = ST_LINK_OK;
        end
      end
      ST_LINK_OK: begin
        if (partner_page_valid) begin
          lp_next      = partner_page;
          page_rx_next = 1'b1;
        end
        if (!sel_link_good) begin
          up_next    = 1'b0; // [RULE_19]
          state_next = ST_BREAK;
        end
      end
      default: begin
        state_next = ST_CONFIG;
      end
    endcase

    // management restart or re-enable; disable drops back to forced
    if (state_reg != ST_CONFIG && state_reg != ST_FORCED) begin
      if (!ctl_negotiation_enable_strap_reg) begin // [RULE_07]
        state_next = ST_FORCED;
      end else if (restart_req || enable_rise) begin // [RULE_18]
        up_next      = 1'b0;
        an_done_next = 1'b0;
        lp_an_next   = 1'b0;
        timer_next   = 32'h0;
        state_next   = ST_BREAK; // [RULE_20]
      end
    end
    if (state_next == ST_BREAK && state_reg != ST_BREAK) begin
      lp_an_next = 1'b0;
      lp_next    = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_CONFIG;
      settle_reg     <= 3'h0;
      timer_reg      <= 32'h0;
      ctl_negotiation_enable_strap_reg  <= 1'b0;
      ctl_speed_reg  <= 1'b0;
      ctl_duplex_reg <= 1'b0;
      armed_reg      <= 1'b0;
      adv_reg        <= 4'h0;
      lp_reg         <= 16'h0000;
      an_done_reg    <= 1'b0;
      pdf_reg        <= 1'b0;
      page_rx_reg    <= 1'b0;
      lp_an_reg      <= 1'b0;
      up_reg         <= 1'b0;
      spd_reg        <= 1'b0;
      fdx_reg        <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= 2'h0;
      rvalid_reg     <= 1'b0;
      rresp_reg      <= 2'h0;
      rdata_reg      <= 32'h0;
    end else begin
      state_reg      <= state_next;
      settle_reg     <= settle_next;
      timer_reg      <= timer_next;
      ctl_negotiation_enable_strap_reg  <= ctl_negotiation_enable_strap_next;
      ctl_speed_reg  <= ctl_speed_next;
      ctl_duplex_reg <= ctl_duplex_next;
      armed_reg      <= armed_next;
      adv_reg        <= adv_next;
      lp_reg         <= lp_next;
      an_done_reg    <= an_done_next;
      pdf_reg        <= pdf_next;
      page_rx_reg    <= page_rx_next;
      lp_an_reg      <= lp_an_next;
      up_reg         <= up_next;
      spd_reg        <= spd_next;
      fdx_reg        <= fdx_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      rvalid_reg     <= rvalid_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready    = wr_take;
  assign s_axi_wready     = wr_take;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = rd_take;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rresp      = rresp_reg;
  assign s_axi_rdata      = rdata_reg;
  assign flp_enable       = (state_reg == ST_ABILITY); // [RULE_05]
  assign flp_code_word    = adv_word;
  assign tx_enable        = (state_reg != ST_BREAK) && (state_reg != ST_CONFIG); // [RULE_20]
  assign link_up          = up_reg;
  assign link_speed_100   = spd_reg;
  assign link_full_duplex = fdx_reg;

endmodule

//--- tb/ancc_top_sva.sv
`timescale 1ns/1ns
module ancc_top_sva #(
  parameter int unsigned BREAK_LINK_CYCLES = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        link_good_10,
  input wire logic        link_good_100,
  input wire logic        flp_enable,
  input wire logic [15:0] flp_code_word,
  input wire logic        tx_enable,
  input wire logic        link_up,
  input wire logic        link_speed_100
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence rd_take; s_axi_arvalid && !s_axi_rvalid; endsequence
  function automatic logic mapped(input logic [31:0] a);
    return a[7:2] inside {6'h00, 6'h01, 6'h04, 6'h05, 6'h06, 6'h10};
  endfunction
  //////////////////////////////////////////////////////////////////////
  // silent cycles since the last burst or data; only judged once a link existed,
  // because the first negotiation after reset has no break to keep
  logic [31:0] quiet_reg;
  logic        seen_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet_reg <= 32'h0;
      seen_reg  <= 1'b0;
    end else begin
      quiet_reg <= (tx_enable || flp_enable) ? 32'h0 : quiet_reg + 32'h1;
      seen_reg  <= seen_reg || link_up;
    end
  end
  //////////////////////////////////////////////////////////////////////
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  rd_answer_a: assert property (rd_take |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read not answered next cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_pair_a: assert property (s_axi_awready |->
    s_axi_wready && s_axi_awvalid && s_axi_wvalid)
    else $error("address taken without data");
  resp_code_a: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (mapped($past(s_axi_awaddr)) ? 2'b00 : 2'b10))
    else $error("write response code wrong");
  break_quiet_a: assert property ($rose(flp_enable) && seen_reg |->
    quiet_reg >= BREAK_LINK_CYCLES - 1)
    else $error("bursts resumed before break time");
  code_word_a: assert property (flp_code_word[4:0] == 5'h01 &&
    flp_code_word[15:9] == 7'h00)
    else $error("burst code word malformed");
  link_cause_a: assert property ($rose(link_up) |->
    (link_speed_100 ? $past(link_good_100) : $past(link_good_10)))
    else $error("link up without receiver link");
endmodule

bind ancc_top ancc_top_sva #(.BREAK_LINK_CYCLES(BREAK_LINK_CYCLES)) i_ancc_top_sva (.*);

//--- tb/ancc_partner.sv
`timescale 1ns/1ns
// far end: link signals and base pages, with a settable answer lag
module ancc_partner (
  input  wire logic        aclk,
  input  wire logic        send,
  input  wire logic [15:0] word,
  input  wire logic [3:0]  lag,
  input  wire logic        has_10,
  input  wire logic        has_100,
  output logic             link_good_10,
  output logic             link_good_100,
  output logic             partner_page_valid,
  output logic [15:0]      partner_page
);
  logic [3:0]  cnt = 4'h0;
  logic        busy = 1'b0;
  logic [15:0] last = 16'h0000;
  initial begin
    link_good_10 = 1'b0;
    link_good_100 = 1'b0;
    partner_page_valid = 1'b0;
    partner_page = 16'hFFFF;
  end
  always @(posedge aclk) begin
    link_good_10 <= has_10;
    link_good_100 <= has_100;
    partner_page_valid <= 1'b0;
    // word outside its pulse is not stale data
    partner_page <= ~last;
    if (send && !busy) begin
      busy <= 1'b1;
      cnt <= lag;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        busy <= 1'b0;
        partner_page_valid <= 1'b1;
        partner_page <= word;
        last <= word;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

//--- tb/autoneg_config_control_bench.sv
`timescale 1ns/1ns
module autoneg_config_control_bench;
  import ancc_pkg::*;
  localparam int BRK = 20;
  logic aclk = 0, aresetn = 0, send = 0, has_10 = 0, has_100 = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, link_good_10, link_good_100, partner_page_valid, flp_enable;
  logic tx_enable, link_up, link_speed_100, link_full_duplex;
  logic negotiation_enable_strap = 1, ability_strap_high = 1, ability_strap_low = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, v;
  logic [15:0] partner_page, flp_code_word, word = 0;
  logic [3:0]  s_axi_wstrb = 4'h3, lag = 4'h7;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  seed = 8'h13;
  int failures = 0, comparisons = 0, cycles = 0, n;
  ancc_top #(.BREAK_LINK_CYCLES(BRK)) i_ancc_top (.*);
  ancc_partner i_ancc_partner (.*);
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // best common mode index, bits {100F,100H,10F,10H}
  function automatic int best(input int c);
    for (int i = 3; i >= 0; i--) if (c[i]) return i;
    return -1;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task wr(input logic [5:0] ix, input logic [15:0] d);
    s_axi_awaddr <= {24'h0, ix, 2'b00};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, 0);
    @(posedge aclk);
  endtask
  task rd(input logic [5:0] ix, input logic [1:0] resp, output logic [31:0] d);
    s_axi_araddr <= {24'h0, ix, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk(s_axi_rresp, resp);
    @(posedge aclk);
  endtask
  // silent cycles until bursts return
  task quiet_span;
    n = 0;
    while (flp_enable !== 1'b1) begin
      n += (tx_enable === 1'b0);
      @(posedge aclk);
    end
    chk(32'(n >= BRK - 1 && n <= BRK + 2), 32'h1);
  endtask
  task finish_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    rd(6'h04, 0, v); chk(v, 32'h01E1);
    rd(6'h01, 0, v); chk(v, 32'h7849);
    rd(6'h07, 2, v); chk(v, 32'h0);
    while (flp_enable !== 1'b1) @(posedge aclk);
    chk(flp_code_word, 32'h01E1);
    // slow page first, link only after it, so parallel detection cannot win
    word <= 16'h2061;
    send <= 1;
    @(posedge aclk);
    send <= 0;
    while (partner_page_valid !== 1'b1) @(posedge aclk);
    has_10 <= 1;
    while (link_up !== 1'b1) @(posedge aclk);
    n = best(4'hF & 4'h3);
    chk({link_speed_100, link_full_duplex}, {n >= 2, n[0]});
    rd(6'h10, 0, v); chk(v, 32'h17);
    rd(6'h01, 0, v); chk(v, 32'h787D);
    rd(6'h05, 0, v); chk(v, 32'h2061);
    rd(6'h06, 0, v); chk(v, 32'h3);
    repeat (3) begin
      seed = lfsr(seed);
      wr(6'h04, {7'h0, seed[3:0], 5'h01});
      rd(6'h04, 0, v); chk(v, {seed[3:0], 5'h01});
    end
    wr(6'h04, 16'h01E1);
    wr(6'h00, 16'h1200);
    quiet_span();
    while (link_up !== 1'b1) @(posedge aclk);
    rd(6'h05, 0, v); chk(v, 32'h0021);
    rd(6'h06, 0, v); chk(v & 32'h1, 32'h0);
    has_10 <= 0;
    has_100 <= 1;
    @(posedge aclk);
    quiet_span();
    while (link_up !== 1'b1) @(posedge aclk);
    rd(6'h05, 0, v); chk(v, 32'h0081);
    rd(6'h10, 0, v); chk(v, 32'h11);
    has_10 <= 1;
    wr(6'h00, 16'h1200);
    quiet_span();
    repeat (4) @(posedge aclk);
    rd(6'h06, 0, v); chk(v & 32'h10, 32'h10);
    wr(6'h00, 16'h0000);
    wr(6'h00, 16'h2100);
    has_10 <= 0;
    repeat (4) @(posedge aclk);
    chk({link_up, link_speed_100, link_full_duplex}, 3'b111);
    // second reset in forced strap mode; later strap changes must not matter
    aresetn <= 0;
    negotiation_enable_strap <= 0;
    ability_strap_low <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    ability_strap_high <= 0;
    repeat (4) @(posedge aclk);
    chk({link_up, link_speed_100, link_full_duplex}, 3'b110);
    wr(6'h00, 16'h3000);
    repeat (4) @(posedge aclk);
    chk({flp_enable, tx_enable}, 2'b01);
    wr(6'h00, 16'h2000);
    wr(6'h00, 16'h3000);
    quiet_span();
    finish_test();
  end
endmodule
